// ---- hdl/hfc_pkg.sv ----
// ==========================================================================
// Holdover frequency configuration constants
package hfc_pkg;
    // ======================================================================
    // Register word indices; the byte address is four times the index
    localparam logic [6:0]  IDX_LOW    = 7'h3e;     // Low byte, bits 7:0
    localparam logic [6:0]  IDX_MID    = 7'h3f;     // Middle byte, bits 15:8
    localparam logic [6:0]  IDX_MODE   = 7'h40;     // Mode and bits 18:16
    localparam logic [6:0]  IDX_CUR0   = 7'h0c;     // Present PLL freq, low byte
    localparam logic [6:0]  IDX_CUR1   = 7'h0d;     // Present PLL freq, middle
    localparam logic [6:0]  IDX_CUR2   = 7'h07;     // Present PLL freq, top bits
    localparam logic [6:0]  IDX_USED   = 7'h7f;     // Frequency in use, local choice
    // Byte addresses as seen on the register bus
    localparam logic [8:0]  ADDR_LOW   = {IDX_LOW, 2'h0};
    localparam logic [8:0]  ADDR_MID   = {IDX_MID, 2'h0};
    localparam logic [8:0]  ADDR_MODE  = {IDX_MODE, 2'h0};
    localparam logic [8:0]  ADDR_CUR0  = {IDX_CUR0, 2'h0};
    localparam logic [8:0]  ADDR_CUR1  = {IDX_CUR1, 2'h0};
    localparam logic [8:0]  ADDR_CUR2  = {IDX_CUR2, 2'h0};
    localparam logic [8:0]  ADDR_USED  = {IDX_USED, 2'h0};
    // ======================================================================
    // Reset values
    localparam logic [7:0]  RST_LOW    = 8'h00;
    localparam logic [7:0]  RST_MID    = 8'h00;
    localparam logic [7:0]  RST_MODE   = 8'h88;
    // ======================================================================
    // Mode register fields
    localparam int          BIT_AUTO   = 7;         // Averaged holdover enable
    localparam int          BIT_FAST   = 6;         // Fast averaging select
    localparam int          BIT_RDAVG  = 5;         // Read back averaged value
    localparam int          MINI_HI    = 4;         // Mini-holdover mode top
    localparam int          MINI_LO    = 3;         // Mini-holdover mode bottom
    localparam int          UP_HI      = 2;         // Upper freq bits top
    // ======================================================================
    // Word format: 19-bit two's complement, 0.0003068 ppm per unit
    localparam int          FREQ_W     = 19;
    localparam real         PPM_PER_LSB = 0.0003068;
    // ======================================================================
    // AXI responses
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : hfc_pkg

// ---- hdl/hfc_top.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Holdover frequency configuration registers
// Software on the register bus programs a 19-bit signed holdover word,
// spread over a low byte, a middle byte and the low bits of the mode byte,
// and the mode fields that steer averaging and mini-holdover.
// The same word format is used by the present frequency report, so a value
// read from there can be filtered and written back without conversion.
// The block also picks the frequency that holdover uses and registers it.
// Limitations: the averagers, the frozen-value capture and mini-holdover
// behaviour sit outside; only their selection is done here.
// Only byte lane 0 of a write carries register bits.
// Status words are read-only: writes to them are answered OKAY and dropped.
// Unmapped addresses answer SLVERR; a read of one returns zero.
// ==========================================================================
module hfc_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [8:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [8:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // PLL side
    input  wire logic [18:0] pll_present_freq_report,
    input  wire logic [18:0] avg_fast_freq,
    input  wire logic [18:0] avg_slow_freq,
    input  wire logic [18:0] frozen_freq,
    input  wire logic        manual_holdover,
    output logic [18:0]      holdover_freq_used,
    output logic [18:0]      manual_holdover_freq,
    output logic             auto_averaging_en,
    output logic             fast_averaging_sel,
    output logic [1:0]       mini_holdover_mode
);
    // ======================================================================
    // Register state
    // The three byte registers are the only storage software can change;
    // everything else here is bus bookkeeping or a registered selection.
    logic [7:0]  low_ff;                // Low byte of holdover word
    logic [7:0]  mid_ff;                // Middle byte of holdover word
    logic [7:0]  mode_ff;               // Mode register
    logic [7:0]  nxt_low;               // Next low byte
    logic [7:0]  nxt_mid;               // Next middle byte
    logic [7:0]  nxt_mode;              // Next mode byte
    logic [18:0] used_ff;               // Frequency chosen for holdover
    logic [18:0] nxt_used;              // Next chosen frequency
    logic [18:0] man_word;              // Assembled manual word
    logic [18:0] avg_word;              // Averager selected by fast bit

    // ======================================================================
    // Write channel state
    // Each channel has a one-beat holding stage
    logic        aw_ff;                 // Address captured
    logic        w_ff;                  // Data captured
    logic [8:0]  awaddr_ff;             // Captured write address
    logic [31:0] wdata_ff;              // Captured write data
    logic [3:0]  wstrb_ff;              // Captured byte strobes
    logic        bvalid_ff;             // Write response pending
    logic [1:0]  bresp_ff;              // Write response code
    logic        awready_ff;            // Address stage can take a beat
    logic        wready_ff;             // Data stage can take a beat
    logic        nxt_awready;
    logic        nxt_wready;
    logic        nxt_aw;
    logic        nxt_w;
    logic [8:0]  nxt_awaddr;
    logic [31:0] nxt_wdata;
    logic [3:0]  nxt_wstrb;
    logic        nxt_bvalid;
    logic [1:0]  nxt_bresp;

    // ======================================================================
    // Read channel state
    logic        rvalid_ff;             // Read answer pending
    logic [31:0] rdata_ff;              // Read answer data
    logic [1:0]  rresp_ff;              // Read answer code
    logic        arready_ff;            // Read address can be taken
    logic        nxt_arready;
    logic        nxt_rvalid;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;

    // ======================================================================
    // Holdover word and averager choice
    // Word assembly: low, middle, then mode bits 2:0 on top
    // Bit 18 is the sign; the word is passed on as raw two's complement
    assign man_word = {mode_ff[hfc_pkg::UP_HI:0], mid_ff, low_ff};
    // The averager output already uses the present-frequency format
    assign avg_word = mode_ff[hfc_pkg::BIT_FAST] ? avg_fast_freq : avg_slow_freq;

    // ======================================================================
    // Write path: address and data accepted in either order
    // A new address may be held while a response is still pending, but the
    // register update waits until that response has gone, so a slow bready
    // never lets two writes land on top of each other.
    always_comb begin
        nxt_aw     = aw_ff;
        nxt_w      = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        nxt_low    = low_ff;
        nxt_mid    = mid_ff;
        nxt_mode   = mode_ff;
        // Take the address beat whenever its holding stage is empty
        if (!aw_ff && s_axi_awvalid) begin
            nxt_aw     = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        // Take the data beat whenever its holding stage is empty
        if (!w_ff && s_axi_wvalid) begin
            nxt_w     = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        // Both halves held and no response pending: perform the write
        if (aw_ff && w_ff && !bvalid_ff) begin
            nxt_aw     = 1'b0;
            nxt_w      = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = hfc_pkg::RESP_OKAY;
            case (awaddr_ff)
                // Only byte lane 0 carries register bits
                hfc_pkg::ADDR_LOW: begin
                    if (wstrb_ff[0]) nxt_low = wdata_ff[7:0];
                end
                hfc_pkg::ADDR_MID: begin
                    if (wstrb_ff[0]) nxt_mid = wdata_ff[7:0];
                end
                hfc_pkg::ADDR_MODE: begin
                    if (wstrb_ff[0]) nxt_mode = wdata_ff[7:0];
                end
                // Read-only status words accept writes silently
                hfc_pkg::ADDR_CUR0, hfc_pkg::ADDR_CUR1,
                hfc_pkg::ADDR_CUR2, hfc_pkg::ADDR_USED: begin
                    nxt_bresp = hfc_pkg::RESP_OKAY;
                end
                // Unmapped: nothing stored, error returned
                default: begin
                    nxt_bresp = hfc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Response leaves once the master has taken it
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        // Ready is registered so each stage stalls while a beat is held
        nxt_awready = !nxt_aw;
        nxt_wready  = !nxt_w;
    end

    // Register the write path
    // Ready flops reset high so the bus sees an idle slave at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 9'h000;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= hfc_pkg::RESP_OKAY;
            low_ff    <= hfc_pkg::RST_LOW;
            mid_ff    <= hfc_pkg::RST_MID;
            mode_ff   <= hfc_pkg::RST_MODE;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
        end else begin
            aw_ff     <= nxt_aw;
            w_ff      <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff  <= nxt_wdata;
            wstrb_ff  <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            low_ff    <= nxt_low;
            mid_ff    <= nxt_mid;
            mode_ff   <= nxt_mode;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
        end
    end

    // ======================================================================
    // Read path: one read at a time, answer one cycle after acceptance
    // The address is not held: data is built from it at the accepting edge,
    // so arready stays low while the answer waits for rready.
    always_comb begin
        logic [18:0] rb_word;
        rb_word    = 19'h00000;
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        // Readback shows averager when BIT_RDAVG is set, so software can refine a manual value
        rb_word = mode_ff[hfc_pkg::BIT_RDAVG] ? avg_word : man_word;
        if (!rvalid_ff && s_axi_arvalid) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = hfc_pkg::RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                hfc_pkg::ADDR_LOW:  nxt_rdata[7:0] = rb_word[7:0];
                hfc_pkg::ADDR_MID:  nxt_rdata[7:0] = rb_word[15:8];
                // Mode bits keep their value; only 2:0 follow the select
                hfc_pkg::ADDR_MODE: nxt_rdata[7:0] = {mode_ff[7:3], rb_word[18:16]};
                // Present frequency words always show the live report
                hfc_pkg::ADDR_CUR0: nxt_rdata[7:0] = pll_present_freq_report[7:0];
                hfc_pkg::ADDR_CUR1: nxt_rdata[7:0] = pll_present_freq_report[15:8];
                hfc_pkg::ADDR_CUR2: nxt_rdata[2:0] = pll_present_freq_report[18:16];
                hfc_pkg::ADDR_USED: nxt_rdata[18:0] = used_ff;
                // Unmapped: zero data with an error code
                default: begin
                    nxt_rresp = hfc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            // Answer taken by the master
            nxt_rvalid = 1'b0;
        end
        // No new address while an answer stands
        nxt_arready = !nxt_rvalid;
    end

    // Register the read path
    // Address ready resets high, matching the empty answer stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= hfc_pkg::RESP_OKAY;
            arready_ff <= 1'b1;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
            arready_ff <= nxt_arready;
        end
    end

    // ======================================================================
    // Holdover source choice: manual always overrides averaging
    // Registered so the PLL side sees a flip-flop; the price is one cycle
    // of lag after a mode write or a change on the averager inputs.
    always_comb begin
        if (manual_holdover) begin
            nxt_used = man_word;
        end else if (mode_ff[hfc_pkg::BIT_AUTO]) begin
            nxt_used = avg_word;
        end else begin
            // Neither manual nor averaged: the frozen value
            nxt_used = frozen_freq;
        end
    end

    // Register the chosen frequency
    // Reset gives zero offset until the first choice is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            used_ff <= 19'h00000;
        end else begin
            used_ff <= nxt_used;
        end
    end

    // ======================================================================
    // Outputs, each from a flip-flop
    assign s_axi_awready        = awready_ff;
    assign s_axi_wready         = wready_ff;
    assign s_axi_bvalid         = bvalid_ff;
    assign s_axi_bresp          = bresp_ff;
    assign s_axi_arready        = arready_ff;
    assign s_axi_rvalid         = rvalid_ff;
    assign s_axi_rdata          = rdata_ff;
    assign s_axi_rresp          = rresp_ff;
    assign holdover_freq_used   = used_ff;
    assign manual_holdover_freq = man_word;
    // Control fields come straight from the mode flip-flops
    assign auto_averaging_en    = mode_ff[hfc_pkg::BIT_AUTO];
    assign fast_averaging_sel   = mode_ff[hfc_pkg::BIT_FAST];
    assign mini_holdover_mode   = mode_ff[hfc_pkg::MINI_HI:hfc_pkg::MINI_LO];
endmodule : hfc_top

// ---- tb/hfc_checker.sv ----
`timescale 1ns/1ps
// ============================================================
// Bus and holdover-source checks, bound onto hfc_top
module hfc_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [18:0] avg_fast_freq,
    input wire logic [18:0] avg_slow_freq,
    input wire logic [18:0] frozen_freq,
    input wire logic        manual_holdover,
    input wire logic [18:0] holdover_freq_used,
    input wire logic [18:0] manual_holdover_freq,
    input wire logic        auto_averaging_en,
    input wire logic        fast_averaging_sel,
    input wire logic [1:0]  mini_holdover_mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [18:0] want_used;  // Source the holdover path must follow
    // Manual wins over averaging, averaging wins over the frozen value
    always_comb begin
        if (manual_holdover) want_used = manual_holdover_freq;
        else if (auto_averaging_en) want_used = fast_averaging_sel ? avg_fast_freq : avg_slow_freq;
        else want_used = frozen_freq;
    end
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answered;
        !s_axi_awready ##[1:3] s_axi_bvalid;
    endsequence
    used_sel_a: assert property ($past(aresetn) |-> holdover_freq_used == $past(want_used))
        else $error("holdover source differs from selection");
    mode_reset_a: assert property ($rose(aresetn) |-> auto_averaging_en && !fast_averaging_sel
        && mini_holdover_mode == 2'h1 && manual_holdover_freq == 19'h0)
        else $error("mode fields not at reset value");
    wr_answer_a: assert property (wr_taken |=> wr_answered)
        else $error("write not answered in time");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    rd_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("read data without request");
    word_write_a: assert property ($changed(manual_holdover_freq) |-> $rose(s_axi_bvalid))
        else $error("holdover word changed without write");
    mode_write_a: assert property ($changed(mini_holdover_mode) |-> $rose(s_axi_bvalid))
        else $error("mode field changed without write");
endmodule : hfc_checker

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the holdover configuration registers
module tb_top;
    logic        aclk = 1'h0, aresetn = 1'h0;  // Clock and active-low reset
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, manual_holdover = 1'h0;
    logic [8:0]  s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [18:0] pll_present_freq_report = 19'h0, avg_fast_freq = 19'h0;
    logic [18:0] avg_slow_freq = 19'h0, frozen_freq = 19'h0;
    logic [18:0] holdover_freq_used, manual_holdover_freq;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        auto_averaging_en, fast_averaging_sel;
    logic [1:0]  s_axi_bresp, s_axi_rresp, mini_holdover_mode;
    int          mismatches = 0, checked = 0;
    always #25 aclk = ~aclk;  // 50 ns period
    hfc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pll_present_freq_report, .avg_fast_freq, .avg_slow_freq, .frozen_freq,
        .manual_holdover, .holdover_freq_used, .manual_holdover_freq, .auto_averaging_en,
        .fast_averaging_sel, .mini_holdover_mode);
    // ============================================================
    // Compare, bus and closing tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic ad, dd;
        ad = 1'h0;
        dd = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin
                ad = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!dd && s_axi_wready) begin
                dd = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp}, {30'h0, hfc_pkg::RESP_OKAY});
        @(posedge aclk);  // Let an edge pass before the next transfer
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [31:0] exp, input logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, resp});
        @(posedge aclk);  // Let an edge pass before the next transfer
    endtask : rd
    task automatic complete_run();
        $display("checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // ============================================================
    // Scenarios
    task automatic t_fields();
        rd(hfc_pkg::ADDR_MODE, 32'h88, hfc_pkg::RESP_OKAY);
        rd(hfc_pkg::ADDR_MID, 32'h0, hfc_pkg::RESP_OKAY);
        wr(hfc_pkg::ADDR_LOW, 8'h5a);
        wr(hfc_pkg::ADDR_MID, 8'hc3);
        wr(hfc_pkg::ADDR_MODE, 8'h5d);
        chk({13'h0, manual_holdover_freq}, {13'h0, 19'h5c35a});
        chk({29'h0, auto_averaging_en, fast_averaging_sel, mini_holdover_mode[1]}, 32'h3);
        rd(hfc_pkg::ADDR_MID, 32'hc3, hfc_pkg::RESP_OKAY);
        rd(hfc_pkg::ADDR_MODE, 32'h5d, hfc_pkg::RESP_OKAY);
        rd(9'h004, 32'h0, hfc_pkg::RESP_SLVERR);
    endtask : t_fields
    // Averaged read-back while the written word stays in force
    task automatic t_readback();
        avg_fast_freq <= 19'h11234;
        avg_slow_freq <= 19'h6789a;
        wr(hfc_pkg::ADDR_LOW, 8'h11);
        wr(hfc_pkg::ADDR_MID, 8'h22);
        wr(hfc_pkg::ADDR_MODE, 8'he3);
        rd(hfc_pkg::ADDR_LOW, 32'h34, hfc_pkg::RESP_OKAY);
        rd(hfc_pkg::ADDR_MODE, 32'he1, hfc_pkg::RESP_OKAY);
        wr(hfc_pkg::ADDR_MODE, 8'ha3);
        rd(hfc_pkg::ADDR_MID, 32'h78, hfc_pkg::RESP_OKAY);
        chk({13'h0, manual_holdover_freq}, {13'h0, 19'h32211});
        wr(hfc_pkg::ADDR_MODE, 8'h83);
        rd(hfc_pkg::ADDR_LOW, 32'h11, hfc_pkg::RESP_OKAY);
    endtask : t_readback
    // Holdover source for each setting; one cycle of lag is allowed
    task automatic t_used();
        frozen_freq <= 19'h00f0f;
        repeat (2) @(posedge aclk);
        chk({13'h0, holdover_freq_used}, 32'h6789a);
        manual_holdover <= 1'h1;
        repeat (2) @(posedge aclk);
        chk({13'h0, holdover_freq_used}, 32'h32211);
        manual_holdover <= 1'h0;
        wr(hfc_pkg::ADDR_MODE, 8'h03);
        repeat (2) @(posedge aclk);
        chk({13'h0, holdover_freq_used}, 32'h00f0f);
        wr(hfc_pkg::ADDR_MODE, 8'hc3);
        repeat (2) @(posedge aclk);
        chk({13'h0, holdover_freq_used}, 32'h11234);
    endtask : t_used
    // Present frequency read out and written back unchanged
    task automatic t_copy();
        pll_present_freq_report <= 19'h5a3c1;
        rd(hfc_pkg::ADDR_CUR0, 32'hc1, hfc_pkg::RESP_OKAY);
        rd(hfc_pkg::ADDR_CUR2, 32'h05, hfc_pkg::RESP_OKAY);
        wr(hfc_pkg::ADDR_LOW, 8'hc1);
        wr(hfc_pkg::ADDR_MID, 8'ha3);
        wr(hfc_pkg::ADDR_MODE, 8'h0d);
        chk({13'h0, manual_holdover_freq}, {13'h0, pll_present_freq_report});
        rd(hfc_pkg::ADDR_CUR1, 32'ha3, hfc_pkg::RESP_OKAY);
        wr(hfc_pkg::ADDR_CUR0, 8'h00);
        chk({13'h0, manual_holdover_freq}, 32'h5a3c1);
        rd(hfc_pkg::ADDR_USED, 32'h00f0f, hfc_pkg::RESP_OKAY);
    endtask : t_copy
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_fields();
        t_readback();
        t_used();
        t_copy();
        complete_run();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule : tb_top
bind hfc_top hfc_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .avg_fast_freq,
    .avg_slow_freq, .frozen_freq, .manual_holdover, .holdover_freq_used, .manual_holdover_freq,
    .auto_averaging_en, .fast_averaging_sel, .mini_holdover_mode);
